/* rtl/lpmm_manager.sv */
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - sleep instruction starts a mode transition
// - deep request, select clear: stop mode
// - deep request, select set: deepest sleep
// - stop halts clocks; enabled sources wake
// - fast wake keeps slow clock running
// - halt stops core only; interrupt wakes
// - inside handler, only recognised interrupt wakes
// - deepest sleep: regulators off, state kept
// - per 4 kB block RAM retention select
// - enabled peripheral and pin wakes accepted
// - enabled reset sources end deepest sleep
// - deepest sleep held until accepted reset
// - fourteen separately enabled pin wakes
// - sleep indicator high in deepest sleep
// - core held until supplies good
// - battery below reset level holds reset
// - battery below warning flags low
// - buck bypass on low headroom, sync
// - per regulator source; analog enable
// - software switch feeds external drive
// - peripheral clocks individually gateable
module lpmm_manager
  import lpmm_pkg::*;
#(
  parameter int NPIN = 14,  // pin wake inputs
  parameter int NRAM = 8,   // 4 kB RAM blocks
  parameter int NPER = 16   // gateable peripheral clocks
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            sleep_retire,
  input  wire logic            core_deep_sleep_request,
  input  wire logic            in_handler,
  input  wire logic            irq_pending,
  input  wire logic            irq_recognised,
  input  wire logic [7:0]      wake_src,
  input  wire logic [NPIN-1:0] pin_wake,
  input  wire logic [6:0]      reset_src,
  input  wire logic            supply_ok,
  input  wire logic            vbat_below_reset,
  input  wire logic            vbat_below_warn,
  input  wire logic            headroom_low,
  output logic                 core_run,
  output logic                 core_clk_en,
  output logic [NPER-1:0]      periph_clk_en,
  output logic                 slow_clk_keep,
  output logic                 regulators_en,
  output logic [2:0]           reg_src_sel,
  output logic                 drive_sel,
  output logic                 buck_bypass,
  output logic                 buck_sync,
  output logic [NRAM-1:0]      ram_retain,
  output logic                 sleep_indicator,
  output logic                 sys_reset,
  output logic                 battery_low
);
  // software registers, reset only by presetn so they survive deep sleep
  logic [8:0]      ctrl;       // control fields
  logic [7:0]      wake_en;    // peripheral wake enables
  logic [NPIN-1:0] pin_en;     // pin wake enables
  logic [6:0]      rst_en;     // accepted reset sources
  logic [NRAM-1:0] ram_ret;    // retained RAM blocks
  logic [NPER-1:0] clk_gate;   // peripheral clock enables
  logic            warn_seen;  // sticky battery-low
  lpmm_state_e     state;      // sequencer state
  lpmm_state_e     next_state; // next sequencer state
  logic            tgt_deep;   // latched sleep target
  logic            tgt_stop;   // latched stop target
  logic            isr_lat;    // sleep issued from a handler
  logic [5:0]      hold_cnt;   // reset stretch counter
  logic            wr_acc;     // write taken this edge
  logic            rd_acc;     // read answered this edge
  logic            irq_ok;     // interrupt may wake
  logic            wake_hit;   // enabled wake source present
  logic            rst_hit;    // enabled reset source present

  // apb access phase completes on the edge where pready is high
  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_acc = psel & penable & ~pready & ~pwrite;

  // wake qualification
  assign irq_ok   = irq_pending & (~isr_lat | irq_recognised);
  assign wake_hit = |(wake_src & wake_en) | |(pin_wake & pin_en);
  assign rst_hit  = |(reset_src & rst_en) | (rst_en[6] & wake_hit);

  // one wait state: pready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (paddr > OFS_STAT);
    end
  end

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= CTRL_RST;
      wake_en  <= '0;
      pin_en   <= '0;
      rst_en   <= '0;
      ram_ret  <= '0;
      clk_gate <= CLKG_RST;
    end else if (wr_acc) begin
      case (paddr)
        OFS_CTRL:   ctrl     <= pwdata[8:0];
        OFS_WAKE:   wake_en  <= pwdata[7:0];
        OFS_PIN:    pin_en   <= pwdata[NPIN-1:0];
        OFS_RSTEN:  rst_en   <= pwdata[6:0];
        OFS_RAMRET: ram_ret  <= pwdata[NRAM-1:0];
        OFS_CLKG:   clk_gate <= pwdata[NPER-1:0];
        default:    ctrl     <= ctrl;                // others ignored
      endcase
    end
  end

  // read data, captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_acc) begin
      case (paddr)
        OFS_CTRL:   prdata <= {23'h0, ctrl};
        OFS_WAKE:   prdata <= {24'h0, wake_en};
        OFS_PIN:    prdata <= 32'(pin_en);
        OFS_RSTEN:  prdata <= {25'h0, rst_en};
        OFS_RAMRET: prdata <= 32'(ram_ret);
        OFS_CLKG:   prdata <= 32'(clk_gate);
        OFS_STAT:   prdata <= {21'h0, buck_bypass, battery_low, warn_seen, tgt_deep, state, core_run};
        default:    prdata <= '0;
      endcase
    end
  end

  // sticky battery-low, write one to bit 2 of status clears; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_seen <= 1'b0;
    end else if (vbat_below_warn) begin
      warn_seen <= 1'b1;
    end else if (wr_acc && paddr == OFS_STAT && pwdata[2]) begin
      warn_seen <= 1'b0;
    end
  end

  // sleep target captured as the instruction retires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_deep <= 1'b0;
      tgt_stop <= 1'b0;
      isr_lat  <= 1'b0;
    end else if (state == ST_RUN && sleep_retire) begin
      tgt_deep <= core_deep_sleep_request & ctrl[B_TSEL];
      tgt_stop <= core_deep_sleep_request & ~ctrl[B_TSEL];
      isr_lat  <= in_handler;
    end
  end

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_PWRUP: begin
        if (supply_ok && !vbat_below_reset) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_retire) begin
          if (!core_deep_sleep_request) begin
            next_state = ST_HALT;
          end else if (ctrl[B_TSEL]) begin
            next_state = ST_DEEP;
          end else begin
            next_state = ST_STOP;
          end
        end
      end
      ST_HALT: begin
        if (irq_ok) begin
          next_state = ST_RUN;
        end
      end
      ST_STOP: begin
        if (wake_hit && (!isr_lat || irq_recognised)) begin
          next_state = ST_RUN;
        end
      end
      ST_DEEP: begin
        if (rst_hit) begin
          next_state = ST_RSTH;
        end
      end
      ST_RSTH: begin
        if (hold_cnt == 6'd0) begin
          next_state = ST_PWRUP;
        end
      end
      default: next_state = ST_PWRUP;
    endcase
    if (vbat_below_reset) begin
      next_state = ST_PWRUP;
    end
  end

  // sequencer state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_PWRUP;
    end else begin
      state <= next_state;
    end
  end

  // reset stretch counter, reloaded every cycle outside the hold state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= '0;
    end else if (state != ST_RSTH) begin
      hold_cnt <= 6'(RST_HOLD_CY - 1);
    end else if (hold_cnt != 6'd0) begin
      hold_cnt <= hold_cnt - 6'd1;
    end
  end

  // clock and power outputs follow the next state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_run        <= 1'b0;
      core_clk_en     <= 1'b0;
      periph_clk_en   <= '0;
      slow_clk_keep   <= 1'b0;
      regulators_en   <= 1'b0;
      ram_retain      <= '0;
      sleep_indicator <= 1'b0;
      sys_reset       <= 1'b1;
    end else begin
      core_run        <= (next_state == ST_RUN);
      core_clk_en     <= (next_state == ST_RUN);
      periph_clk_en   <= (next_state == ST_RUN || next_state == ST_HALT) ? clk_gate : '0;
      slow_clk_keep   <= (next_state == ST_STOP) ? ctrl[B_FWAKE] : 1'b0;
      regulators_en   <= ctrl[B_APWR] & (next_state != ST_DEEP);
      ram_retain      <= (next_state == ST_DEEP) ? ram_ret : '0;
      sleep_indicator <= (next_state == ST_DEEP);
      sys_reset       <= (next_state == ST_PWRUP) | (next_state == ST_RSTH);
    end
  end

  // supply routing and monitor outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_src_sel <= '0;
      drive_sel   <= 1'b0;
      buck_bypass <= 1'b0;
      buck_sync   <= 1'b0;
      battery_low <= 1'b0;
    end else begin
      reg_src_sel <= ctrl[B_RSEL +: 3];
      drive_sel   <= ctrl[B_DRV];
      buck_bypass <= headroom_low;
      buck_sync   <= ctrl[B_SYNC];
      battery_low <= vbat_below_warn;
    end
  end

  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sleep_deep;
    state == ST_RUN && sleep_retire && core_deep_sleep_request && ctrl[B_TSEL] && !vbat_below_reset;
  endsequence
  sequence s_sleep_stop;
    state == ST_RUN && sleep_retire && core_deep_sleep_request && !ctrl[B_TSEL] && !vbat_below_reset;
  endsequence

  property p_deep_entry;
    s_sleep_deep |=> state == ST_DEEP ##0 sleep_indicator && !regulators_en;
  endproperty
  a_deep_entry: assert property (p_deep_entry) else $error("deep target not entered");

  property p_stop_entry;
    s_sleep_stop |=> state == ST_STOP && !core_clk_en && periph_clk_en == '0;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop target not entered");

  property p_halt_wake;
    state == ST_HALT && irq_pending && !isr_lat && !vbat_below_reset |=> core_run;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt did not wake");

  property p_isr_block;
    state == ST_HALT && isr_lat && !irq_recognised && !vbat_below_reset |=> state == ST_HALT;
  endproperty
  a_isr_block: assert property (p_isr_block) else $error("unrecognised irq woke core");

  property p_deep_stay;
    state == ST_DEEP && !rst_hit && !vbat_below_reset |=> state == ST_DEEP;
  endproperty
  a_deep_stay: assert property (p_deep_stay) else $error("left deep sleep unprompted");

  property p_deep_exit;
    state == ST_DEEP && rst_hit && !vbat_below_reset |=> sys_reset && !sleep_indicator;
  endproperty
  a_deep_exit: assert property (p_deep_exit) else $error("accepted reset ignored");

  property p_supply_hold;
    !supply_ok |=> !core_run;
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("core ran before supply ok");

  property p_vbat_reset;
    vbat_below_reset |=> sys_reset && !core_run;
  endproperty
  a_vbat_reset: assert property (p_vbat_reset) else $error("low battery did not reset");

  property p_warn;
    vbat_below_warn |=> battery_low && warn_seen;
  endproperty
  a_warn: assert property (p_warn) else $error("battery low not flagged");

  property p_target_held;
    state == ST_DEEP |-> $stable(tgt_deep) || $past(state) == ST_RUN;
  endproperty
  a_target_held: assert property (p_target_held) else $error("target changed in sleep");

  property p_fast_wake;
    state == ST_STOP && $past(state) == ST_STOP |-> slow_clk_keep == $past(ctrl[B_FWAKE]);
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("fast wake clock wrong");

  property p_stop_wake;
    state == ST_STOP && !wake_hit |=> state != ST_RUN;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop woke without source");

  // retention and sleep indicator stay off outside deepest sleep
  property p_retain_idle;
    state != ST_DEEP |-> ram_retain == '0 && !sleep_indicator;
  endproperty
  a_retain_idle: assert property (p_retain_idle) else $error("retention outside deep sleep");

  // an accepted reset in deepest sleep is stretched, not a single pulse
  sequence s_deep_reset;
    state == ST_DEEP && rst_hit;
  endsequence
  property p_reset_stretch;
    s_deep_reset |=> sys_reset [*8];
  endproperty
  a_reset_stretch: assert property (p_reset_stretch) else $error("reset stretch cut short");

  // halt keeps the gated peripheral clocks and stops only the core clock
  property p_halt_clocks;
    state == ST_HALT |-> periph_clk_en == $past(clk_gate) && !core_clk_en;
  endproperty
  a_halt_clocks: assert property (p_halt_clocks) else $error("halt clocks wrong");

  // a clear with no new warning drops the sticky flag
  property p_warn_clear;
    wr_acc && paddr == OFS_STAT && pwdata[2] && !vbat_below_warn |=> !warn_seen;
  endproperty
  a_warn_clear: assert property (p_warn_clear) else $error("battery low flag not cleared");
endmodule

/* rtl/lpmm_pkg.sv */
package lpmm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_WAKE   = 8'h04;
  localparam logic [7:0] OFS_PIN    = 8'h08;
  localparam logic [7:0] OFS_RSTEN  = 8'h0c;
  localparam logic [7:0] OFS_RAMRET = 8'h10;
  localparam logic [7:0] OFS_CLKG   = 8'h14;
  localparam logic [7:0] OFS_STAT   = 8'h18;
  // control field positions
  localparam int B_TSEL  = 0;  // deep_sleep_target_select
  localparam int B_FWAKE = 1;  // stop_mode_wake_config fast wake
  localparam int B_FSRC  = 2;  // fast wake source: 0 low_freq_osc, 1 rtc_timer_clock
  localparam int B_APWR  = 3;  // analog power system enable
  localparam int B_RSEL  = 4;  // regulator_group input selects, 3 bits
  localparam int B_DRV   = 7;  // external_drive_supply switch
  localparam int B_SYNC  = 8;  // buck switching synchronised to system clock
  // reset values
  localparam logic [8:0]  CTRL_RST = 9'h008;
  localparam logic [15:0] CLKG_RST = 16'hffff;
  // stretch of the reset pulse issued on deepest-sleep exit
  localparam int CLK_NS      = 40;
  localparam int RST_HOLD_NS = 1000;
  localparam int RST_HOLD_CY = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // sequencer states
  typedef enum logic [5:0] {
    ST_PWRUP = 6'h01,
    ST_RUN   = 6'h02,
    ST_HALT  = 6'h04,
    ST_STOP  = 6'h08,
    ST_DEEP  = 6'h10,
    ST_RSTH  = 6'h20
  } lpmm_state_e;
endpackage

/* tb/lpmm_core_model.sv */
`timescale 1ns/1ps
// core side: retires a wait instruction after a chosen lag, only while executing
module lpmm_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       core_run,                 // core may execute
  input  wire logic       irq_pending,              // any interrupt pending
  input  wire logic       do_sleep,                 // one-cycle request from the bench
  input  wire logic [3:0] lag,                      // cycles before the instruction retires
  input  wire logic       deep,                     // deep request level to present
  input  wire logic       handler,                  // instruction issued inside a handler
  input  wire logic       high_prio,                // pending interrupt outranks the handler
  output logic            sleep_retire,
  output logic            core_deep_sleep_request,
  output logic            in_handler,
  output logic            irq_recognised
);
  logic [3:0] wait_cnt;                             // lag still to run
  logic       pend;                                 // instruction in flight
  // mode selects are levels set before the instruction
  assign core_deep_sleep_request = deep;
  assign in_handler              = handler;
  // priority filter of the core
  assign irq_recognised          = irq_pending & high_prio;
  // a halted core executes nothing, so retire waits for core_run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend         <= 1'b0;
      wait_cnt     <= 4'h0;
      sleep_retire <= 1'b0;
    end else begin
      sleep_retire <= 1'b0;
      if (do_sleep && !pend) begin
        pend     <= 1'b1;
        wait_cnt <= lag;
      end else if (pend && core_run) begin
        if (wait_cnt == 4'h0) begin
          sleep_retire <= 1'b1;
          pend         <= 1'b0;
        end else begin
          wait_cnt <= wait_cnt - 4'h1;
        end
      end
    end
  end
endmodule

/* tb/lpmm_tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module low_power_mode_manager_tb_top;
  import lpmm_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, wake_src = 8'h00;
  logic [31:0] pwdata = 32'h0, rnd = 32'h182e2;   // 99042
  logic        supply_ok = 1'b0, vbat_below_reset = 1'b0, vbat_below_warn = 1'b0, headroom_low = 1'b0;
  logic        irq_pending = 1'b0, do_sleep = 1'b0, deep = 1'b0, handler = 1'b0, high_prio = 1'b0;
  logic [3:0]  lag = 4'h0;
  logic [13:0] pin_wake = 14'h0;
  logic [6:0]  reset_src = 7'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, sleep_retire, core_deep_sleep_request, in_handler, irq_recognised;
  logic        core_run, core_clk_en, slow_clk_keep, regulators_en, drive_sel, buck_bypass, buck_sync;
  logic        sleep_indicator, sys_reset, battery_low;
  logic [15:0] periph_clk_en;
  logic [2:0]  reg_src_sel;
  logic [7:0]  ram_retain;
  logic [64:0] exp_q[$];                          // {slverr, mask, data} per read
  logic [64:0] note;
  int          err_count = 0, samples_checked = 0, hold_n;
  always #20 pclk = ~pclk;
  lpmm_manager dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sleep_retire, .core_deep_sleep_request, .in_handler, .irq_pending, .irq_recognised, .wake_src, .pin_wake,
    .reset_src, .supply_ok, .vbat_below_reset, .vbat_below_warn, .headroom_low, .core_run, .core_clk_en,
    .periph_clk_en, .slow_clk_keep, .regulators_en, .reg_src_sel, .drive_sel, .buck_bypass, .buck_sync,
    .ram_retain, .sleep_indicator, .sys_reset, .battery_low);
  lpmm_core_model core (.pclk, .presetn, .core_run, .irq_pending, .do_sleep, .lag, .deep, .handler, .high_prio,
    .sleep_retire, .core_deep_sleep_request, .in_handler, .irq_recognised);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic summarize();
    if (err_count == 0 && samples_checked > 0 && exp_q.size() == 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    // setup always starts right at a rising edge
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic er);
    exp_q.push_back({er, m, e & m});
    apb(1'b0, a, 32'h0);
  endtask
  // bounded wait for core_run, counting cycles of reset on the way
  task automatic wait_run(input logic v);
    int i;
    hold_n = 0;
    for (i = 0; i < 100 && core_run !== v; i++) begin
      tick(1);
      if (sys_reset === 1'b1) hold_n++;
    end
    `CHK(core_run, v)
    if (core_run !== v) summarize();
  endtask
  task automatic sleep_go(input logic d, input logic h);
    @(posedge pclk);
    deep <= d;
    handler <= h;
    lag <= rnd[3:0];
    do_sleep <= 1'b1;
    rnd = lfsr(rnd);
    @(posedge pclk);
    do_sleep <= 1'b0;
    wait_run(1'b0);
  endtask
  // read watcher: oldest note against returned data; an empty queue gives x and fails
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      note = exp_q.pop_front();
      `CHK({pslverr, prdata & note[63:32]}, {note[64], note[31:0]})
    end
  end
  initial begin
    int k;
    logic [31:0] v;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    tick(3);
    `CHK(sys_reset, 1'b1)
    `CHK(core_run, 1'b0)
    supply_ok <= 1'b1;
    wait_run(1'b1);
    `CHK(sys_reset, 1'b0)
    rd(OFS_CTRL, {23'h0, CTRL_RST}, 32'hffffffff, 1'b0);
    rd(OFS_CLKG, {16'h0, CLKG_RST}, 32'hffffffff, 1'b0);
    rd(8'h1c, 32'h0, 32'hffffffff, 1'b1);
    for (k = 0; k < 4; k++) begin
      v = rnd;
      rnd = lfsr(rnd);
      wr(OFS_CTRL, v & 32'h1fe);
      wr(OFS_CLKG, v >> 16);
      tick(1);
      `CHK(reg_src_sel, v[6:4])
      `CHK(regulators_en, v[3])
      `CHK(drive_sel, v[7])
      `CHK(buck_sync, v[8])
      `CHK(periph_clk_en, v[31:16])
    end
    // halt: core stops, peripherals keep their clocks
    wr(OFS_CTRL, 32'h8);
    sleep_go(1'b0, 1'b0);
    `CHK(core_clk_en, 1'b0)
    `CHK(periph_clk_en, v[31:16])
    rd(OFS_STAT, {25'h0, ST_HALT, 1'b0}, 32'h7f, 1'b0);
    irq_pending <= 1'b1;
    wait_run(1'b1);
    irq_pending <= 1'b0;
    // halt from a handler: low priority interrupt must not wake
    sleep_go(1'b0, 1'b1);
    irq_pending <= 1'b1;
    tick(4);
    `CHK(core_run, 1'b0)
    high_prio <= 1'b1;
    wait_run(1'b1);
    irq_pending <= 1'b0;
    high_prio <= 1'b0;
    handler <= 1'b0;
    // stop with fast wake, only comparator wake enabled
    wr(OFS_WAKE, 32'h08);
    wr(OFS_CTRL, 32'ha);
    sleep_go(1'b1, 1'b0);
    `CHK(periph_clk_en, 16'h0)
    `CHK(core_clk_en, 1'b0)
    `CHK(slow_clk_keep, 1'b1)
    rd(OFS_STAT, {25'h0, ST_STOP, 1'b0}, 32'h7f, 1'b0);
    wake_src <= 8'hf7;
    tick(4);
    `CHK(core_run, 1'b0)
    wake_src <= 8'hff;
    wait_run(1'b1);
    wake_src <= 8'h00;
    // first and last pin wake, others active but disabled
    wr(OFS_WAKE, 32'h0);
    for (k = 0; k < 14; k += 13) begin
      wr(OFS_PIN, 32'h1 << k);
      sleep_go(1'b1, 1'b0);
      pin_wake <= ~(14'h1 << k);
      tick(4);
      `CHK(core_run, 1'b0)
      pin_wake <= 14'h3fff;
      wait_run(1'b1);
      pin_wake <= 14'h0;
    end
    // deepest sleep: each peripheral wake source through the wake reset, then reset sources 0 to 5
    wr(OFS_PIN, 32'h0);
    for (k = 0; k < 14; k++) begin
      v = rnd & 32'hff;
      rnd = lfsr(rnd);
      wr(OFS_WAKE, k < 8 ? 32'h1 << k : 32'h0);
      wr(OFS_RSTEN, k < 8 ? 32'h40 : 32'h1 << (k - 8));
      wr(OFS_RAMRET, v);
      wr(OFS_CTRL, 32'h9);
      sleep_go(1'b1, 1'b0);
      deep <= 1'b0;
      `CHK(sleep_indicator, 1'b1)
      `CHK(regulators_en, 1'b0)
      `CHK(ram_retain, v[7:0])
      wake_src <= k < 8 ? ~(8'h1 << k) : 8'hff;
      reset_src <= k < 8 ? 7'h3f : ~(7'h1 << (k - 8)) & 7'h3f;
      tick(4);
      `CHK(sleep_indicator, 1'b1)
      wake_src <= 8'hff;
      reset_src <= 7'h3f;
      wait_run(1'b1);
      wake_src <= 8'h0;
      reset_src <= 7'h0;
      `CHK(hold_n >= RST_HOLD_CY, 1'b1)
      `CHK(ram_retain, 8'h0)
      rd(OFS_RAMRET, v, 32'hffffffff, 1'b0);
    end
    // supply monitor and buck bypass
    vbat_below_warn <= 1'b1;
    headroom_low <= 1'b1;
    tick(3);
    `CHK(battery_low, 1'b1)
    `CHK(buck_bypass, 1'b1)
    vbat_below_warn <= 1'b0;
    tick(2);
    rd(OFS_STAT, 32'h100, 32'h300, 1'b0);
    wr(OFS_STAT, 32'h4);
    rd(OFS_STAT, 32'h0, 32'h300, 1'b0);
    vbat_below_reset <= 1'b1;
    tick(3);
    `CHK(sys_reset, 1'b1)
    `CHK(core_run, 1'b0)
    vbat_below_reset <= 1'b0;
    wait_run(1'b1);
    tick(2);
    summarize();
  end
endmodule
